// ===== instr_decode_pkg.sv
/*
 * shared constants, types and field layout for the instruction decoder.
 * assumes one 16-bit instruction word per instruction cycle from fetch.
 */
package instr_decode_pkg;

	// ==========================================================
	// widths and cycle timing
	localparam int INSTR_W  = 16;
	localparam int QUARTERS = 4;   // oscillator periods per instruction cycle
	localparam int PH_W     = 2;

	// ==========================================================
	// class prefixes, matched on the top bits of the word
	localparam int         PFX_BYTE_W = 2;
	localparam logic [1:0] PFX_BYTE   = 2'h0;
	localparam int         PFX_MOVP_W = 2;
	localparam logic [1:0] PFX_MOVP   = 2'h1;
	localparam int         PFX_BIT_W  = 3;
	localparam logic [2:0] PFX_BIT    = 3'h4;
	localparam int         PFX_TBL_W  = 4;
	localparam logic [3:0] PFX_TBL    = 4'ha;
	localparam int         PFX_LIT_W  = 4;
	localparam logic [3:0] PFX_LIT    = 4'hb;
	localparam int         PFX_JMP_W  = 2;
	localparam logic [1:0] PFX_JMP    = 2'h3;

	// ==========================================================
	// field positions
	localparam int F_LSB       = 0;
	localparam int F_MSB       = 7;
	localparam int DEST_BIT    = 8;
	localparam int BOP_LSB     = 9;
	localparam int BOP_MSB     = 13;
	localparam int BSEL_LSB    = 8;
	localparam int BSEL_MSB    = 10;
	localparam int BITOP_LSB   = 11;
	localparam int BITOP_MSB   = 12;
	localparam int P_LSB       = 8;
	localparam int P_MSB       = 12;
	localparam int MOVP_DIR    = 13;
	localparam int TBL_INC_BIT = 8;
	localparam int TBL_HI_BIT  = 9;
	localparam int TOP_LSB     = 10;
	localparam int TOP_MSB     = 11;
	localparam int LOP_LSB     = 8;
	localparam int LOP_MSB     = 11;
	localparam int K8_MSB      = 7;
	localparam int K13_MSB     = 12;
	localparam int JMP_CALL    = 13;
	localparam int CTRL_LSB    = 0;
	localparam int CTRL_MSB    = 7;

	// ==========================================================
	// operation code ranges
	localparam logic [4:0] BOP_CTRL       = 5'h00;
	localparam logic [4:0] BOP_SKIP_FIRST = 5'h18;
	localparam logic [4:0] BOP_SKIP_LAST  = 5'h1b;
	localparam logic [4:0] BOP_S_FIRST    = 5'h1c;
	localparam logic [4:0] BOP_LAST       = 5'h1d;
	localparam int         BITOP_SKIP_BIT = 1;
	localparam logic [3:0] LOP_LAST       = 4'hb;
	localparam logic [7:0] CTRL_NOP       = 8'h00;
	localparam logic [7:0] CTRL_RETURN    = 8'h02;
	localparam logic [7:0] CTRL_SLEEP     = 8'h03;
	localparam logic [7:0] CTRL_CLRWDT    = 8'h04;
	localparam logic [7:0] CTRL_RETFIE    = 8'h05;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		FMT_BYTE = 2'b00,
		FMT_BIT  = 2'b01,
		FMT_LIT  = 2'b11,
		FMT_RSVD = 2'b10
	} fmt_e;

	typedef enum logic {
		CYC_EXEC = 1'b0,
		CYC_NOP  = 1'b1
	} cyc_e;

	typedef struct packed {
		fmt_e        fmt;
		logic        rsvd;
		logic [4:0]  op_code;
		logic [7:0]  file_addr;
		logic [4:0]  periph_addr;
		logic [2:0]  bit_sel;
		logic        working_register_wr;
		logic        file_wr;
		logic [7:0]  lit8;
		logic [12:0] lit13;
		logic        tbl_op;
		logic        tbl_inc;
		logic        tbl_hi;
		logic        skip_op;
		logic        pc_op;
	} decode_s;

endpackage

// ===== phase_gen.sv
/*
 * quarter-cycle counter: splits each instruction cycle into oscillator periods.
 * assumes clk is the core oscillator and reset_n the core reset.
 */
`timescale 1ns/1ps

module phase_gen #(
	parameter int PHASES = instr_decode_pkg::QUARTERS
) (
	input  wire logic                            clk,
	input  wire logic                            reset_n,
	output logic [instr_decode_pkg::PH_W-1:0]    phase,
	output logic                                 last
);
	import instr_decode_pkg::*;

	localparam logic [PH_W-1:0] PH_END = PH_W'(PHASES - 1);

	logic [PH_W-1:0] phase_nxt;

	// ==========================================================
	// wrap after the final quarter
	always_comb begin
		phase_nxt = (phase == PH_END) ? '0 : phase + 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase <= '0;
		end else begin
			phase <= phase_nxt;
		end
	end

	assign last = (phase == PH_END);

endmodule

// ===== prefix_match.sv
/*
 * compares the top bits of an instruction word with one class prefix.
 * assumes the word is at most 16 bits and the prefix is narrower.
 */
`timescale 1ns/1ps

module prefix_match #(
	parameter int                W    = 2,
	parameter logic [W-1:0]      CODE = '0
) (
	input  wire logic [instr_decode_pkg::INSTR_W-1:0] word,
	output logic                                      hit
);
	import instr_decode_pkg::*;

	// ==========================================================
	// pure compare, no state
	always_comb begin
		hit = (word[INSTR_W-1 -: W] == CODE);
	end

endmodule

// ===== instr_decode_cycle_timing.sv
/*
 * instruction decode and cycle timing for the 8-bit core.
 * assumes fetch presents a word with fetch_valid on the clock of the core,
 * and the datapath reports skip_true and pc_write during the last quarter.
 */
`timescale 1ns/1ps

module instr_decode_cycle_timing #(
	parameter int PHASES = instr_decode_pkg::QUARTERS
) (
	input  wire logic                                  clk,
	input  wire logic                                  reset_n,
	input  wire logic [instr_decode_pkg::INSTR_W-1:0]  instr_word,
	input  wire logic                                  fetch_valid,
	input  wire logic                                  skip_true,
	input  wire logic                                  pc_write,
	output instr_decode_pkg::decode_s                  dec_r,
	output logic                                       exec_valid_r,
	output logic [instr_decode_pkg::PH_W-1:0]          phase_r,
	output logic                                       cycle_start_r,
	output logic                                       nop_cycle_r,
	output logic                                       two_cycle_r,
	output logic                                       instr_taken_r
);
	import instr_decode_pkg::*;

	// ==========================================================
	// quarter counter and class matchers
	logic            ph_last;
	logic            hit_byte;
	logic            hit_movp;
	logic            hit_bit;
	logic            hit_tbl;
	logic            hit_lit;
	logic            hit_jmp;

	// one instruction cycle is PHASES oscillator periods
	phase_gen #(.PHASES(PHASES)) u_phase (
		.clk     (clk),
		.reset_n (reset_n),
		.phase   (phase_r),
		.last    (ph_last)
	);

	prefix_match #(.W(PFX_BYTE_W), .CODE(PFX_BYTE)) u_m_byte (
		.word (instr_word),
		.hit  (hit_byte)
	);

	prefix_match #(.W(PFX_MOVP_W), .CODE(PFX_MOVP)) u_m_movp (
		.word (instr_word),
		.hit  (hit_movp)
	);

	prefix_match #(.W(PFX_BIT_W), .CODE(PFX_BIT)) u_m_bit (
		.word (instr_word),
		.hit  (hit_bit)
	);

	prefix_match #(.W(PFX_TBL_W), .CODE(PFX_TBL)) u_m_tbl (
		.word (instr_word),
		.hit  (hit_tbl)
	);

	prefix_match #(.W(PFX_LIT_W), .CODE(PFX_LIT)) u_m_lit (
		.word (instr_word),
		.hit  (hit_lit)
	);

	prefix_match #(.W(PFX_JMP_W), .CODE(PFX_JMP)) u_m_jmp (
		.word (instr_word),
		.hit  (hit_jmp)
	);

	// ==========================================================
	// class select: control words share the byte prefix, so they are
	// peeled off first; the other prefixes never overlap
	logic cls_ctrl;
	logic cls_byte;
	logic cls_movp;
	logic cls_bit;
	logic cls_tbl;
	logic cls_lit;
	logic cls_jmp;

	// a word with d/s set and opcode zero is a reserved byte code, not control
	always_comb begin
		cls_ctrl = hit_byte && (instr_word[BOP_MSB:DEST_BIT] == 6'h00);
		cls_byte = hit_byte && !cls_ctrl;
		cls_movp = hit_movp;
		cls_bit  = hit_bit;
		cls_tbl  = hit_tbl;
		cls_lit  = hit_lit;
		cls_jmp  = hit_jmp;
	end

	// ==========================================================
	// field split of the incoming word
	decode_s    split;
	logic [4:0] bop;
	logic [1:0] bitop;
	logic [3:0] lop;
	logic [7:0] ctrl;
	logic       dest;

	// one word in, one decoded record out; no state here
	always_comb begin
		bop   = instr_word[BOP_MSB:BOP_LSB];
		bitop = instr_word[BITOP_MSB:BITOP_LSB];
		lop   = instr_word[LOP_MSB:LOP_LSB];
		ctrl  = instr_word[CTRL_MSB:CTRL_LSB];
		dest  = instr_word[DEST_BIT];
		split = '0;
		split.fmt = FMT_RSVD;
		split.rsvd = 1'b1;
		// operand fields sit at fixed positions in every class
		split.file_addr   = instr_word[F_MSB:F_LSB];
		split.periph_addr = instr_word[P_MSB:P_LSB];
		split.bit_sel     = instr_word[BSEL_MSB:BSEL_LSB];
		split.lit8        = instr_word[K8_MSB:0];
		split.lit13       = instr_word[K13_MSB:0];
		// class order matters: control codes hide inside the byte prefix
		if (cls_ctrl) begin
			split.fmt = FMT_LIT;
			split.op_code = ctrl[4:0];
			// the low byte names the control operation
			case (ctrl)
				CTRL_NOP, CTRL_SLEEP, CTRL_CLRWDT: begin
					split.rsvd = 1'b0;
				end
				CTRL_RETURN, CTRL_RETFIE: begin
					split.rsvd  = 1'b0;
					split.pc_op = 1'b1;
				end
				default: begin
					split.rsvd = 1'b1;
				end
			endcase
		end else if (cls_byte) begin
			split.fmt     = FMT_BYTE;
			split.op_code = bop;
			split.rsvd    = (bop == BOP_CTRL) || (bop > BOP_LAST);
			split.skip_op = (bop >= BOP_SKIP_FIRST) && (bop <= BOP_SKIP_LAST);
			if (bop >= BOP_S_FIRST) begin
				// s form: file always written, working register when s is 0
				split.file_wr = 1'b1;
				split.working_register_wr = ~dest;
			end else if (!split.skip_op) begin
				split.file_wr = dest;
				split.working_register_wr = ~dest;
			end
		end else if (cls_movp) begin
			// peripheral move, direction bit goes to op_code; file_wr is set for either direction
			split.fmt     = FMT_BYTE;
			split.rsvd    = 1'b0;
			split.op_code = {4'h0, instr_word[MOVP_DIR]};
			split.file_wr = 1'b1;
		end else if (cls_bit) begin
			split.fmt     = FMT_BIT;
			split.rsvd    = 1'b0;
			split.op_code = {3'h0, bitop};
			split.skip_op = bitop[BITOP_SKIP_BIT];
			split.file_wr = ~bitop[BITOP_SKIP_BIT];
		end else if (cls_tbl) begin
			split.fmt     = FMT_LIT;
			split.rsvd    = 1'b0;
			split.op_code = {3'h0, instr_word[TOP_MSB:TOP_LSB]};
			split.tbl_op  = 1'b1;
			split.tbl_inc = instr_word[TBL_INC_BIT];
			split.tbl_hi  = instr_word[TBL_HI_BIT];
			split.file_wr = ~instr_word[TOP_LSB];
		end else if (cls_lit) begin
			split.fmt     = FMT_LIT;
			split.op_code = {1'b0, lop};
			split.rsvd    = (lop > LOP_LAST);
			split.working_register_wr = (lop <= LOP_LAST);
		end else if (cls_jmp) begin
			// jump and call carry the wide literal
			split.fmt     = FMT_LIT;
			split.rsvd    = 1'b0;
			split.op_code = {4'h0, instr_word[JMP_CALL]};
			split.pc_op   = 1'b1;
		end
		// reserved words must not disturb any state
		if (split.rsvd) begin
			split.working_register_wr = 1'b0;
			split.file_wr = 1'b0;
			split.tbl_op  = 1'b0;
			split.skip_op = 1'b0;
			split.pc_op   = 1'b0;
		end
	end

	// ==========================================================
	// instruction cycle sequencing
	cyc_e    state_r;
	cyc_e    state_nxt;
	decode_s dec_nxt;
	logic    exec_valid_nxt;
	logic    cycle_start_nxt;
	logic    nop_cycle_nxt;
	logic    two_cycle_nxt;
	logic    instr_taken_nxt;
	logic    needs_two;
	logic    load;
	logic    two_tbl;
	logic    two_pc;
	logic    two_skip;
	logic    two_write;

	// reasons for a second cycle, kept apart so each can be traced alone;
	// a pc write only counts when the instruction really writes a file
	assign two_tbl   = dec_r.tbl_op;
	assign two_pc    = dec_r.pc_op;
	assign two_skip  = dec_r.skip_op & skip_true;
	assign two_write = dec_r.file_wr & pc_write;
	// an empty cycle never stretches, whatever the datapath reports
	assign needs_two = exec_valid_r & (two_tbl | two_pc | two_skip | two_write);

	// decisions are taken on the last quarter so datapath results are final
	always_comb begin
		state_nxt       = state_r;
		dec_nxt         = dec_r;
		exec_valid_nxt  = exec_valid_r;
		nop_cycle_nxt   = nop_cycle_r;
		two_cycle_nxt   = two_cycle_r;
		cycle_start_nxt = ph_last;
		instr_taken_nxt = 1'b0;
		load            = 1'b0;
		if (ph_last) begin
			case (state_r)
				CYC_EXEC: begin
					if (needs_two) begin
						// hold the fetched word and run an idle cycle
						state_nxt      = CYC_NOP;
						exec_valid_nxt = 1'b0;
						nop_cycle_nxt  = 1'b1;
						two_cycle_nxt  = 1'b1;
					end else begin
						load = 1'b1;
					end
				end
				CYC_NOP: begin
					// pad cycle over: the word held by fetch goes in now
					load = 1'b1;
				end
				default: begin
					// an impossible state code recovers by loading
					load = 1'b1;
				end
			endcase
		end
		if (load) begin
			state_nxt       = CYC_EXEC;
			nop_cycle_nxt   = 1'b0;
			two_cycle_nxt   = 1'b0;
			exec_valid_nxt  = fetch_valid;
			instr_taken_nxt = fetch_valid;
			// no word from fetch runs as an empty cycle
			dec_nxt         = fetch_valid ? split : '0;
		end
	end

	// registers only; every decision is made in the comb block above
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r       <= CYC_EXEC;
			dec_r         <= '0;
			exec_valid_r  <= 1'b0;
			cycle_start_r <= 1'b0;
			nop_cycle_r   <= 1'b0;
			two_cycle_r   <= 1'b0;
			instr_taken_r <= 1'b0;
		end else begin
			state_r       <= state_nxt;
			dec_r         <= dec_nxt;
			exec_valid_r  <= exec_valid_nxt;
			cycle_start_r <= cycle_start_nxt;
			nop_cycle_r   <= nop_cycle_nxt;
			two_cycle_r   <= two_cycle_nxt;
			instr_taken_r <= instr_taken_nxt;
		end
	end

endmodule

// ===== decode_timing_sva.sv
/*
 * checker for the decode and cycle timing outputs.
 * assumes it sees only the top ports; bound to every instance below.
 */
`timescale 1ns/1ps

// ==========================================================
// checker
module decode_timing_sva #(
	parameter int PHASES = instr_decode_pkg::QUARTERS
) (
	input wire logic                                  clk,
	input wire logic                                  reset_n,
	input wire logic [instr_decode_pkg::INSTR_W-1:0]  instr_word,
	input wire logic                                  fetch_valid,
	input wire logic                                  skip_true,
	input wire logic                                  pc_write,
	input wire instr_decode_pkg::decode_s             dec_r,
	input wire logic                                  exec_valid_r,
	input wire logic [instr_decode_pkg::PH_W-1:0]     phase_r,
	input wire logic                                  cycle_start_r,
	input wire logic                                  nop_cycle_r,
	input wire logic                                  two_cycle_r,
	input wire logic                                  instr_taken_r
);
	import instr_decode_pkg::*;

	// last quarter of an instruction cycle
	localparam logic [PH_W-1:0] PH_LAST = PH_W'(PHASES - 1);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// the same reasons that make an instruction take two cycles
	logic needs_two;
	logic at_end;
	assign needs_two = dec_r.tbl_op | dec_r.pc_op | (dec_r.skip_op & skip_true)
		| (dec_r.file_wr & pc_write);
	assign at_end = exec_valid_r && phase_r == PH_LAST;

	sequence s_nop4;
		nop_cycle_r [*4] ##1 !nop_cycle_r;
	endsequence

	property p_wrap;
		phase_r == PH_LAST |=> cycle_start_r && phase_r == 2'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("phase wrap wrong");
	property p_quarter;
		cycle_start_r |=> !cycle_start_r [*3] ##1 cycle_start_r;
	endproperty
	a_quarter: assert property (p_quarter) else $error("cycle not four clocks");
	property p_two;
		at_end && needs_two |=> nop_cycle_r && !exec_valid_r;
	endproperty
	a_two: assert property (p_two) else $error("no second cycle");
	property p_one;
		at_end && !needs_two |=> !nop_cycle_r;
	endproperty
	a_one: assert property (p_one) else $error("extra cycle");
	property p_len;
		$rose(nop_cycle_r) |-> cycle_start_r ##0 s_nop4;
	endproperty
	a_len: assert property (p_len) else $error("no_operation cycle length");
	property p_hold;
		nop_cycle_r |-> $stable(dec_r) && !instr_taken_r;
	endproperty
	a_hold: assert property (p_hold) else $error("decode moved in pad cycle");
	property p_pair;
		two_cycle_r == nop_cycle_r;
	endproperty
	a_pair: assert property (p_pair) else $error("two-cycle flag apart");
	property p_fields;
		instr_taken_r && $past(fetch_valid) && !dec_r.rsvd |->
			dec_r.file_addr == $past(instr_word[7:0]) &&
			dec_r.bit_sel == $past(instr_word[10:8]) &&
			dec_r.lit13 == $past(instr_word[12:0]);
	endproperty
	a_fields: assert property (p_fields) else $error("operand field");
	property p_taken;
		instr_taken_r |-> cycle_start_r && $past(phase_r) == PH_LAST;
	endproperty
	a_taken: assert property (p_taken) else $error("load off phase");
endmodule

bind instr_decode_cycle_timing decode_timing_sva #(.PHASES(PHASES)) u_sva (
	.clk           (clk),
	.reset_n       (reset_n),
	.instr_word    (instr_word),
	.fetch_valid   (fetch_valid),
	.skip_true     (skip_true),
	.pc_write      (pc_write),
	.dec_r         (dec_r),
	.exec_valid_r  (exec_valid_r),
	.phase_r       (phase_r),
	.cycle_start_r (cycle_start_r),
	.nop_cycle_r   (nop_cycle_r),
	.two_cycle_r   (two_cycle_r),
	.instr_taken_r (instr_taken_r)
);

// ===== fetch_model.sv
/*
 * model of program fetch and the datapath results.
 * assumes the bench sets offer_* values; they reach the pins 1 ns after an edge.
 */
`timescale 1ns/1ps

// ==========================================================
// fetch and datapath model
module fetch_model (
	input wire logic        clk,
	input wire logic [15:0] offer_word,
	input wire logic        offer_valid,
	input wire logic        offer_skip,
	input wire logic        offer_pcw,
	output logic [15:0]     instr_word,
	output logic            fetch_valid,
	output logic            skip_true,
	output logic            pc_write
);
	initial begin
		instr_word = 16'h0000;
		fetch_valid = 1'b0;
		skip_true = 1'b0;
		pc_write = 1'b0;
	end
	// an idle bus flips each cycle so a stale word cannot pass for a real one
	always @(posedge clk) begin
		#1;
		fetch_valid = offer_valid;
		instr_word = offer_valid ? offer_word : ~instr_word;
		skip_true = offer_skip;
		pc_write = offer_pcw;
	end
endmodule

// ===== tb.sv
/*
 * self-checking bench for the instruction decoder.
 * assumes fetch_model drives the fetch and datapath inputs.
 */
`timescale 1ns/1ps

// ==========================================================
// bench
module tb;
	import instr_decode_pkg::*;
	logic        clk, reset_n, fetch_valid, skip_true, pc_write;
	logic [15:0] instr_word, offer_word;
	logic        offer_valid, offer_skip, offer_pcw;
	decode_s     dec_r;
	logic        exec_valid_r, cycle_start_r, nop_cycle_r, two_cycle_r, instr_taken_r;
	logic [1:0]  phase_r;
	int          err_total, comparisons, cycles;

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	instr_decode_cycle_timing dut (.clk(clk), .reset_n(reset_n), .instr_word(instr_word),
		.fetch_valid(fetch_valid), .skip_true(skip_true), .pc_write(pc_write),
		.dec_r(dec_r), .exec_valid_r(exec_valid_r), .phase_r(phase_r),
		.cycle_start_r(cycle_start_r), .nop_cycle_r(nop_cycle_r),
		.two_cycle_r(two_cycle_r), .instr_taken_r(instr_taken_r));
	fetch_model u_fetch (.clk(clk), .offer_word(offer_word), .offer_valid(offer_valid),
		.offer_skip(offer_skip), .offer_pcw(offer_pcw), .instr_word(instr_word),
		.fetch_valid(fetch_valid), .skip_true(skip_true), .pc_write(pc_write));

	task give_verdict;
		if (err_total == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task chk(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask

	// offer one word, wait for it to be taken, then let fetch go idle
	task load(input logic [15:0] w, input logic sk, input logic pw);
		int n;
		offer_word = w;
		offer_valid = 1'b1;
		offer_skip = sk;
		offer_pcw = pw;
		n = 0;
		@(posedge clk) #2;
		while (instr_taken_r !== 1'b1 && n < 40) begin
			@(posedge clk) #2;
			n++;
		end
		offer_valid = 1'b0;
		chk(instr_taken_r === 1'b1 && dec_r.file_addr === w[7:0], "word not taken");
	endtask

	// four clocks on, the pad cycle must be there only when expected
	task tail(input logic two);
		repeat (4) @(posedge clk);
		#2;
		chk(nop_cycle_r === two && two_cycle_r === two, "cycle count");
	endtask

	task t_byte;
		load(16'h025a, 1'b0, 1'b0);
		chk(dec_r.fmt === FMT_BYTE && dec_r.working_register_wr === 1'b1 && dec_r.file_wr === 1'b0, "d0");
		tail(1'b0);
		load(16'h0342, 1'b0, 1'b1);
		chk(dec_r.file_wr === 1'b1 && dec_r.working_register_wr === 1'b0, "d1");
		tail(1'b1);
	endtask

	task t_s_bit;
		load(16'h38ff, 1'b0, 1'b0);
		chk(dec_r.file_wr === 1'b1 && dec_r.working_register_wr === 1'b1, "s0");
		tail(1'b0);
		load(16'h39ff, 1'b0, 1'b0);
		chk(dec_r.file_wr === 1'b1 && dec_r.working_register_wr === 1'b0, "s1");
		tail(1'b0);
		load(16'h8710, 1'b0, 1'b0);
		chk(dec_r.fmt === FMT_BIT && dec_r.bit_sel === 3'h7, "bit field");
		tail(1'b0);
		load(16'h9320, 1'b1, 1'b0);
		chk(dec_r.skip_op === 1'b1, "skip op");
		tail(1'b1);
		load(16'h9320, 1'b0, 1'b0);
		tail(1'b0);
	endtask

	task t_tbl;
		load(16'ha233, 1'b0, 1'b0);
		chk(dec_r.tbl_op === 1'b1 && dec_r.tbl_hi === 1'b1 && dec_r.tbl_inc === 1'b0, "t1");
		tail(1'b1);
		load(16'ha533, 1'b0, 1'b0);
		chk(dec_r.tbl_inc === 1'b1 && dec_r.tbl_hi === 1'b0, "i1");
		tail(1'b1);
	endtask

	task t_lit;
		load(16'hb3c3, 1'b0, 1'b0);
		chk(dec_r.fmt === FMT_LIT && dec_r.lit8 === 8'hc3 && dec_r.working_register_wr === 1'b1, "k8");
		tail(1'b0);
		load(16'hfabc, 1'b0, 1'b0);
		chk(dec_r.lit13 === 13'h1abc && dec_r.pc_op === 1'b1, "k13");
		tail(1'b1);
		load(16'h5f33, 1'b0, 1'b0);
		chk(dec_r.periph_addr === 5'h1f && dec_r.file_addr === 8'h33, "p");
		tail(1'b0);
		load(16'h3c00, 1'b1, 1'b1);
		chk(dec_r.rsvd === 1'b1 && dec_r.pc_op === 1'b0, "reserved");
		tail(1'b0);
	endtask

	// control words, a byte skip and reserved codes; datapath flags must stretch only the byte skip
	task t_ctrl;
		load(16'h0000, 1'b1, 1'b1);
		chk(dec_r.fmt === FMT_LIT && dec_r.rsvd === 1'b0 && dec_r.file_wr === 1'b0, "ctl");
		tail(1'b0);
		load(16'h0002, 1'b0, 1'b0);
		chk(dec_r.pc_op === 1'b1 && dec_r.rsvd === 1'b0, "return");
		tail(1'b1);
		load(16'h3055, 1'b1, 1'b0);
		chk(dec_r.fmt === FMT_BYTE && dec_r.skip_op === 1'b1 && dec_r.file_wr === 1'b0, "bskip");
		tail(1'b1);
		load(16'hbd00, 1'b0, 1'b0);
		chk(dec_r.rsvd === 1'b1 && dec_r.working_register_wr === 1'b0, "reserved literal");
		tail(1'b0);
		load(16'h0155, 1'b0, 1'b1);
		chk(dec_r.rsvd === 1'b1 && dec_r.file_wr === 1'b0, "op zero");
		tail(1'b0);
	endtask

	// a hang is cut short well past the 166 clocks the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			give_verdict();
		end
	end

	initial begin
		reset_n = 1'b0;
		offer_word = 16'h0000;
		offer_valid = 1'b0;
		offer_skip = 1'b0;
		offer_pcw = 1'b0;
		repeat (4) @(posedge clk);
		#1 reset_n = 1'b1;
		t_byte();
		t_s_bit();
		t_tbl();
		t_lit();
		t_ctrl();
		@(posedge clk) #1 reset_n = 1'b0;
		#2 chk(dec_r === '0 && phase_r === 2'h0 && nop_cycle_r === 1'b0, "reset");
		@(posedge clk) #1 reset_n = 1'b1;
		t_byte();
		give_verdict();
	end
endmodule
